// ### include/proc_state_regs.vh
// constants for the processor state controller
//
// Function
// - The core is always in exactly one of four states: normal, background, exception or halted.
// - Fetching operands or executing instructions is reported as the normal state.
// - An idle or low-power idle instruction puts the core into a stopped part of normal with no bus cycles.
// - A trace, interrupt or exception request while stopped resumes instruction execution; a reset leaves the core in the exception state.
// - Exception processing stacks, fetches the vector and refills the pipeline.
// - Exception processing ends when the handler's first instruction starts executing.
// - A bus or address error during exception processing halts the core when debug is disabled, including a fault on a fault.
// - A background state separate from normal operation exists for debugging.
// - A no-operation instruction stalls until every earlier instruction has completed.
// - Breakpoint, double fault or the debug entry opcode with debug enabled enters background and raises the debug-entered output.
// - With debug disabled, two successive bus faults halt the core.
`ifndef PROC_STATE_REGS_VH
`define PROC_STATE_REGS_VH
// ----------------------------------------
// state codes
// ----------------------------------------
`define PST_NORMAL 2'h0
`define PST_BACKGROUND 2'h1
`define PST_EXCEPTION 2'h2
`define PST_HALTED 2'h3
// ----------------------------------------
// exception sequence steps
// ----------------------------------------
`define EXS_STACK 2'h0
`define EXS_VECTOR 2'h1
`define EXS_REFILL 2'h2
`define EXS_HANDLER 2'h3
// ----------------------------------------
// timing counts
// ----------------------------------------
`define STACK_WORDS 3'h4
`define REFILL_WORDS 3'h2
// debug entry source codes
`define DBG_SRC_BREAK 2'h0
`define DBG_SRC_OPCODE 2'h1
`define DBG_SRC_DFAULT 2'h3
`endif

// ### rtl/exception_sequencer.v
// exception stacking, vector fetch and pipeline refill sequencer
`timescale 1ns/10ps
`default_nettype none
`include "proc_state_regs.vh"
module exception_sequencer (
  input wire core_clk,
  input wire rst_b,
  input wire start,
  input wire abort,
  input wire busAck,
  output reg busReq,
  output reg [1:0] step,
  output reg done
);
  reg [2:0] count;
  reg active;

  // step through stack, vector and refill, one bus ack per word
  always @(posedge core_clk)
  begin
    if (!rst_b || abort)
    begin
      active <= 1'b0;
      busReq <= 1'b0;
      step <= `EXS_STACK;
      count <= 3'h0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !active)
      begin
        active <= 1'b1;
        busReq <= 1'b1;
        step <= `EXS_STACK;
        count <= 3'h0;
      end
      else if (active && busAck)
      begin
        case (step)
          `EXS_STACK:
          begin
            if (count == `STACK_WORDS - 3'h1)
            begin
              step <= `EXS_VECTOR;
              count <= 3'h0;
            end
            else
              count <= count + 3'h1;
          end
          `EXS_VECTOR:
            step <= `EXS_REFILL;
          `EXS_REFILL:
          begin
            if (count == `REFILL_WORDS - 3'h1)
            begin
              step <= `EXS_HANDLER;
              active <= 1'b0;
              busReq <= 1'b0;
              done <= 1'b1;
            end
            else
              count <= count + 3'h1;
          end
          default:
            step <= `EXS_STACK;
        endcase
      end
    end
  end
endmodule // exception_sequencer
`default_nettype wire

// ### rtl/proc_state_ctrl.v
// processing state controller for the core
`timescale 1ns/10ps
`default_nettype none
`include "proc_state_regs.vh"
module proc_state_ctrl (
  input wire core_clk,
  input wire rst_b,
  input wire debugEnable,
  input wire breakpointRequest,
  input wire decodeIdle,
  input wire decodeLowPowerIdle,
  input wire decodeDebugEntry,
  input wire decodeNop,
  input wire pipelineEmpty,
  input wire instrIssue,
  input wire exceptionRequest,
  input wire traceEvent,
  input wire interruptEvent,
  input wire busError,
  input wire addressError,
  input wire busAck,
  input wire debugResume,
  output reg [1:0] procState,
  output reg stopped,
  output reg lowPower,
  output reg fetchEnable,
  output reg nopStall,
  output reg debugEntered,
  output reg [1:0] debugSource,
  output reg exceptionBusReq,
  output reg [1:0] exceptionStep,
  output reg handlerStart
);
  // ----------------------------------------
  // exception sequencer
  // ----------------------------------------
  wire seqBusReq;
  wire [1:0] seqStep;
  wire seqDone;
  wire faultNow;
  wire seqStart;
  wire seqAbort;
  reg [1:0] next_state;
  reg faultSeen;

  assign faultNow = busError || addressError;
  assign seqStart = (procState == `PST_NORMAL) && next_state == `PST_EXCEPTION;
  assign seqAbort = (procState != `PST_EXCEPTION);

  exception_sequencer i_exception_sequencer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(seqStart),
    .abort(seqAbort && !seqStart),
    .busAck(busAck),
    .busReq(seqBusReq),
    .step(seqStep),
    .done(seqDone)
  );

  // true for a debug entry cause
  function dbg_cause;
    input brk;
    input op;
    input dfault;
    begin
      dbg_cause = brk || op || dfault;
    end
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  wire doubleFault;
  wire wakeEvent;
  assign doubleFault = faultNow && faultSeen;
  assign wakeEvent = traceEvent || interruptEvent || exceptionRequest;

  // one state code at a time
  always @*
  begin
    next_state = procState;
    case (procState)
      `PST_NORMAL:
      begin
        if (debugEnable && dbg_cause(breakpointRequest, decodeDebugEntry, doubleFault))
          next_state = `PST_BACKGROUND;
        else if (doubleFault)
          next_state = `PST_HALTED;
        else if (faultNow || exceptionRequest || (stopped && wakeEvent))
          next_state = `PST_EXCEPTION;
        else if (decodeDebugEntry)
          next_state = `PST_EXCEPTION; // illegal trap when debug disabled
      end
      `PST_EXCEPTION:
      begin
        if (faultNow && debugEnable)
          next_state = `PST_BACKGROUND;
        else if (faultNow)
          next_state = `PST_HALTED;
        else if (seqDone)
          next_state = `PST_NORMAL;
      end
      `PST_BACKGROUND:
      begin
        if (debugResume)
          next_state = `PST_NORMAL;
      end
      `PST_HALTED:
        next_state = `PST_HALTED;
      default:
        next_state = `PST_HALTED;
    endcase
  end

  // ----------------------------------------
  // state and outputs
  // ----------------------------------------
  // state register with registered outputs
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      procState <= `PST_EXCEPTION;
      stopped <= 1'b0;
      lowPower <= 1'b0;
      fetchEnable <= 1'b0;
      nopStall <= 1'b0;
      debugEntered <= 1'b0;
      debugSource <= `DBG_SRC_BREAK;
      exceptionBusReq <= 1'b0;
      exceptionStep <= `EXS_STACK;
      handlerStart <= 1'b0;
      faultSeen <= 1'b0;
    end
    else
    begin
      procState <= next_state;
      exceptionBusReq <= seqBusReq && next_state == `PST_EXCEPTION;
      exceptionStep <= seqStep;
      handlerStart <= seqDone && next_state == `PST_NORMAL;
      // remember a fault until the handler starts
      if (seqDone)
        faultSeen <= 1'b0;
      else if (faultNow)
        faultSeen <= 1'b1;
      // stopped sub-condition of normal
      if (next_state != `PST_NORMAL || (stopped && wakeEvent))
      begin
        stopped <= 1'b0;
        lowPower <= 1'b0;
      end
      else if (instrIssue && (decodeIdle || decodeLowPowerIdle))
      begin
        stopped <= 1'b1;
        lowPower <= decodeLowPowerIdle;
      end
      // no-op waits for earlier instructions to finish
      nopStall <= (next_state == `PST_NORMAL) && decodeNop && !pipelineEmpty;
      // fetch only while normal and running
      fetchEnable <= (next_state == `PST_NORMAL) && !stopped
        && !(instrIssue && (decodeIdle || decodeLowPowerIdle))
        && !(decodeNop && !pipelineEmpty);
      debugEntered <= (next_state == `PST_BACKGROUND);
      if (next_state == `PST_BACKGROUND && procState != `PST_BACKGROUND)
      begin
        if (doubleFault || procState == `PST_EXCEPTION)
          debugSource <= `DBG_SRC_DFAULT;
        else if (decodeDebugEntry)
          debugSource <= `DBG_SRC_OPCODE;
        else
          debugSource <= `DBG_SRC_BREAK;
      end
    end
  end
endmodule // proc_state_ctrl
`default_nettype wire

// ### tb/proc_state_ctrl_monitor.sv
// assertion checker for the processing state controller
`timescale 1ns/10ps
`default_nettype none
module proc_state_ctrl_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic debugEnable,
  input wire logic pipelineEmpty,
  input wire logic exceptionRequest,
  input wire logic traceEvent,
  input wire logic interruptEvent,
  input wire logic busError,
  input wire logic addressError,
  input wire logic [1:0] procState,
  input wire logic stopped,
  input wire logic fetchEnable,
  input wire logic nopStall,
  input wire logic debugEntered,
  input wire logic [1:0] debugSource,
  input wire logic exceptionBusReq,
  input wire logic handlerStart
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_halt_hold; procState == 2'h3 |=> procState == 2'h3 && !fetchEnable; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left");
  property p_fault_halt; procState == 2'h2 && (busError || addressError) && !debugEnable
    |=> procState == 2'h3; endproperty
  a_fault_halt: assert property (p_fault_halt) else $error("no halt on fault");
  property p_fault_dbg; procState == 2'h2 && busError && debugEnable
    |=> procState == 2'h1 && debugSource == 2'h3; endproperty
  a_fault_dbg: assert property (p_fault_dbg) else $error("no debug on fault");
  property p_dbg_flag; debugEntered == (procState == 2'h1); endproperty
  a_dbg_flag: assert property (p_dbg_flag) else $error("debug flag wrong");
  property p_stop; stopped |-> procState == 2'h0 && !fetchEnable; endproperty
  a_stop: assert property (p_stop) else $error("fetch while stopped");
  property p_wake; stopped && (traceEvent || interruptEvent) |=> !stopped; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_nop; nopStall && pipelineEmpty |=> !nopStall; endproperty
  a_nop: assert property (p_nop) else $error("stall held");
  property p_handler; handlerStart |-> procState == 2'h0 && !exceptionBusReq ##1 !handlerStart;
  endproperty
  a_handler: assert property (p_handler) else $error("bad handler start");
  property p_entry; procState == 2'h0 && exceptionRequest && !debugEnable
    |=> procState == 2'h2 ##1 exceptionBusReq; endproperty
  a_entry: assert property (p_entry) else $error("bad exception entry");
endmodule // proc_state_ctrl_monitor
bind proc_state_ctrl proc_state_ctrl_monitor i_proc_state_ctrl_monitor (.*);
`default_nettype wire

// ### tb/proc_state_ctrl_test.sv
// self-checking bench for the processing state controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module proc_state_ctrl_test;
  logic core_clk = 0, rst_b = 0, debugEnable = 0, breakpointRequest = 0, decodeIdle = 0;
  logic decodeLowPowerIdle = 0, decodeDebugEntry = 0, decodeNop = 0, pipelineEmpty = 1;
  logic instrIssue = 0, exceptionRequest = 0, traceEvent = 0, interruptEvent = 0;
  logic busError = 0, addressError = 0, busAck = 0, debugResume = 0;
  wire [1:0] procState, debugSource, exceptionStep;
  wire stopped, lowPower, fetchEnable, nopStall, debugEntered, exceptionBusReq, handlerStart;
  int miscompares = 0, samplesChecked = 0;
  proc_state_ctrl i_proc_state_ctrl (.*);
  // 250 MHz core clock
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic tick(int n = 1); repeat (n) @(negedge core_clk); endtask
  task automatic pulse(ref logic s); s = 1; tick(); s = 0; endtask
  // feeds the seven words, waits for the handler to start
  task automatic ackAll();
    int k;
    repeat (7)
    begin
      for (k = 0; k < 20 && !exceptionBusReq; k++) tick();
      pulse(busAck);
    end
    for (k = 0; k < 20 && handlerStart !== 1'b1; k++) tick();
    `CHK("procState", 2'h0, procState)
    `CHK("handlerStart", 1'b1, handlerStart)
    `CHK("exceptionStep", 2'h3, exceptionStep)
    tick();
  endtask
  // reset mid-run, fault into background, resume, second fault with debug off halts
  task automatic t_double_fault();
    rst_b = 0;
    tick(3);
    rst_b = 1;
    tick();
    `CHK("procState", 2'h2, procState)
    debugEnable = 1;
    pulse(busError);
    `CHK("procState", 2'h1, procState)
    debugEnable = 0;
    pulse(debugResume);
    `CHK("procState", 2'h0, procState)
    pulse(busError);
    `CHK("procState", 2'h3, procState)
    `CHK("fetchEnable", 1'b0, fetchEnable)
    $display("double fault done");
  endtask
  task automatic t_fault_debug();
    `CHK("procState", 2'h2, procState)
    debugEnable = 1;
    pulse(busError);
    `CHK("procState", 2'h1, procState)
    `CHK("debugSource", 2'h3, debugSource)
    `CHK("debugEntered", 1'b1, debugEntered)
    pulse(debugResume);
    `CHK("fetchEnable", 1'b1, fetchEnable)
    $display("fault to background done");
  endtask
  task automatic t_exception();
    debugEnable = 0;
    pulse(exceptionRequest);
    `CHK("procState", 2'h2, procState)
    tick();
    `CHK("exceptionBusReq", 1'b1, exceptionBusReq)
    `CHK("exceptionStep", 2'h0, exceptionStep)
    ackAll();
    $display("exception walk done");
  endtask
  task automatic t_stop(bit lp);
    decodeIdle = !lp;
    decodeLowPowerIdle = lp;
    pulse(instrIssue);
    decodeIdle = 0;
    decodeLowPowerIdle = 0;
    tick();
    `CHK("stopped", 1'b1, stopped)
    `CHK("lowPower", lp, lowPower)
    `CHK("fetchEnable", 1'b0, fetchEnable)
    if (lp) pulse(interruptEvent);
    else pulse(traceEvent);
    `CHK("stopped", 1'b0, stopped)
    if (procState === 2'h2) ackAll();
    $display("stop and wake done");
  endtask
  task automatic t_nop();
    decodeNop = 1;
    pipelineEmpty = 0;
    tick(2);
    `CHK("nopStall", 1'b1, nopStall)
    pipelineEmpty = 1;
    tick();
    decodeNop = 0;
    tick();
    `CHK("nopStall", 1'b0, nopStall)
    $display("nop done");
  endtask
  task automatic t_debug_entry();
    debugEnable = 1;
    pulse(breakpointRequest);
    `CHK("debugSource", 2'h0, debugSource)
    pulse(debugResume);
    pulse(decodeDebugEntry);
    `CHK("debugSource", 2'h1, debugSource)
    pulse(debugResume);
    `CHK("procState", 2'h0, procState)
    $display("debug entry done");
  endtask
  task automatic t_halt();
    debugEnable = 0;
    pulse(exceptionRequest);
    tick();
    pulse(addressError);
    `CHK("procState", 2'h3, procState)
    pulse(exceptionRequest);
    pulse(debugResume);
    tick(3);
    `CHK("procState", 2'h3, procState)
    `CHK("fetchEnable", 1'b0, fetchEnable)
    $display("halt done");
  endtask
  task automatic printVerdict();
    $display("checked %0d mismatched %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #20000;
    miscompares++;
    printVerdict();
  end
  // main sequence
  initial
  begin
    tick(3);
    rst_b = 1;
    tick();
    t_fault_debug();
    t_exception();
    t_stop(0);
    t_stop(1);
    t_nop();
    t_debug_entry();
    t_halt();
    t_double_fault();
    printVerdict();
  end
endmodule // proc_state_ctrl_test
`default_nettype wire
